// ==== rtl/ceb_defines.svh ====
// Purpose: Shared constants for the CPU byte lane steering ends
// Assumes: 32-bit multiplexed address/data link, one clock
// Notes:   Definitions only
`ifndef CEB_DEFINES_SVH
`define CEB_DEFINES_SVH

// ==========================================================
// Address decode
`define CEB_REGION_MSB   31
`define CEB_REGION_LSB   28
`define CEB_REGION_ROM   4'hF
`define CEB_REGION_IO    4'hB

// ==========================================================
// Lane masks, reset values and ROM byte sequencing
`define CEB_MASK_BYTE    4'h1
`define CEB_MASK_LOHALF  4'h3
`define CEB_MASK_HIHALF  4'hC
`define CEB_MASK_WORD    4'hF
`define CEB_RST_LITTLE   1'h0
`define CEB_RST_WORD     32'h0000_0000
`define CEB_ROM_LAST     2'h3
`define CEB_ROM_STEP     32'h0000_0001
`define CEB_WORD_ALIGN   2'h0

`endif

// ==== rtl/ceb_pkg.sv ====
// Purpose: Types shared by both ends of the lane steering link
// Assumes: Constants live in ceb_defines.svh
// Notes:   Nothing here is imported; users write ceb_pkg::name
package ceb_pkg;

  // ==========================================================
  // Transfer sizes
  typedef enum logic [1:0] {
    CEB_BYTE,
    CEB_HALF,
    CEB_WORD
  } ceb_size_t;

  // ==========================================================
  // State machines
  typedef enum logic [2:0] {
    DEV_IDLE,
    DEV_WDATA,
    DEV_DECODE,
    DEV_ROM,
    DEV_IO,
    DEV_MEM,
    DEV_RESP
  } ceb_dev_state_t;

  typedef enum logic [1:0] {
    CPU_IDLE,
    CPU_DATA,
    CPU_WAIT
  } ceb_cpu_state_t;

endpackage

// ==== rtl/ceb_link_if.sv ====
// Purpose: Multiplexed address/data link between CPU and board logic
// Assumes: One driver for all four lanes at a time, selected by output enables
// Notes:   The shared wire is resolved here from the enables
`include "ceb_defines.svh"
interface ceb_link_if;

  logic              cmd_valid;
  logic              cmd_write;
  ceb_pkg::ceb_size_t cmd_size;
  logic              data_valid;
  logic              ack;
  logic [31:0]       cpu_ad_out;
  logic              cpu_ad_oe;
  logic [31:0]       dev_ad_out;
  logic              dev_ad_oe;
  logic [31:0]       system_addr_data_bus;

  // ==========================================================
  // Wire resolution; an undriven bus reads as zero
  assign system_addr_data_bus = cpu_ad_oe ? cpu_ad_out :
                                dev_ad_oe ? dev_ad_out : `CEB_RST_WORD;

  modport cpu (
    output cmd_valid, cmd_write, cmd_size, data_valid, cpu_ad_out, cpu_ad_oe,
    input  ack, system_addr_data_bus
  );

  modport dev (
    input  cmd_valid, cmd_write, cmd_size, data_valid, system_addr_data_bus,
    output ack, dev_ad_out, dev_ad_oe
  );

endinterface

// ==== rtl/ceb_cpu_end.sv ====
// Purpose: CPU end: issues transfers and steers bytes to its lanes
// Assumes: One transfer outstanding at a time
// Notes:   User data is right justified; lanes follow CPU_LITTLE
`include "ceb_defines.svh"
module ceb_cpu_end (
  ceb_link_if.cpu            link,
  input  wire logic          REF_CLK,
  input  wire logic          RST_N,
  input  wire logic          CPU_LITTLE,
  input  wire logic          REQ,
  input  wire logic          REQ_WRITE,
  input  wire logic [1:0]    REQ_SIZE,
  input  wire logic [31:0]   REQ_ADDR,
  input  wire logic [31:0]   REQ_WDATA,
  output logic               BUSY,
  output logic               DONE,
  output logic [31:0]        RDATA
);

  ceb_pkg::ceb_cpu_state_t state,     next_state;
  ceb_pkg::ceb_size_t      size,      next_size;
  logic [31:0]             wdata,     next_wdata;
  logic [4:0]              shift,     next_shift;
  logic                    write,     next_write;
  logic                    cmd_valid, next_cmd_valid;
  logic                    data_valid, next_data_valid;
  logic [31:0]             ad_out,    next_ad_out;
  logic                    ad_oe,     next_ad_oe;
  logic                    busy,      next_busy;
  logic                    done,      next_done;
  logic [31:0]             rdata,     next_rdata;
  logic [1:0]              lane;

  // ==========================================================
  // Lane choice from the CPU's own byte ordering
  always_comb begin
    if (REQ_SIZE == 2'(ceb_pkg::CEB_HALF)) begin
      lane = CPU_LITTLE ? {REQ_ADDR[1], 1'b0} : {~REQ_ADDR[1], 1'b0};
    end else begin
      lane = CPU_LITTLE ? REQ_ADDR[1:0] : ~REQ_ADDR[1:0];
    end
  end

  // ==========================================================
  // Sequencing
  always_comb begin
    next_state      = state;
    next_size       = size;
    next_wdata      = wdata;
    next_shift      = shift;
    next_write      = write;
    next_cmd_valid  = 1'b0;
    next_data_valid = 1'b0;
    next_ad_out     = `CEB_RST_WORD;
    next_ad_oe      = 1'b0;
    next_busy       = busy;
    next_done       = 1'b0;
    next_rdata      = rdata;
    unique case (state)
      ceb_pkg::CPU_IDLE: begin
        if (REQ) begin
          next_size      = ceb_pkg::ceb_size_t'(REQ_SIZE);
          next_write     = REQ_WRITE;
          next_shift     = (REQ_SIZE == 2'(ceb_pkg::CEB_WORD)) ? 5'h0 : {lane, 3'b000};
          next_wdata     = REQ_WDATA;
          next_cmd_valid = 1'b1;
          next_ad_out    = REQ_ADDR;
          next_ad_oe     = 1'b1;
          next_busy      = 1'b1;
          next_state     = REQ_WRITE ? ceb_pkg::CPU_DATA : ceb_pkg::CPU_WAIT;
        end
      end
      ceb_pkg::CPU_DATA: begin
        next_data_valid = 1'b1;
        next_ad_oe      = 1'b1;
        unique case (size)
          ceb_pkg::CEB_BYTE: next_ad_out = {24'h00_0000, wdata[7:0]} << shift;
          ceb_pkg::CEB_HALF: next_ad_out = {16'h0000, wdata[15:0]} << shift;
          default:           next_ad_out = wdata;
        endcase
        next_state = ceb_pkg::CPU_WAIT;
      end
      ceb_pkg::CPU_WAIT: begin
        if (link.ack) begin
          unique case (size)
            ceb_pkg::CEB_BYTE: next_rdata = (link.system_addr_data_bus >> shift) & 32'h0000_00FF;
            ceb_pkg::CEB_HALF: next_rdata = (link.system_addr_data_bus >> shift) & 32'h0000_FFFF;
            default:           next_rdata = link.system_addr_data_bus;
          endcase
          if (write) begin
            next_rdata = rdata;
          end
          next_done  = 1'b1;
          next_busy  = 1'b0;
          next_state = ceb_pkg::CPU_IDLE;
        end
      end
      default: next_state = ceb_pkg::CPU_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state      <= ceb_pkg::CPU_IDLE;
      size       <= ceb_pkg::CEB_WORD;
      wdata      <= `CEB_RST_WORD;
      shift      <= 5'h0;
      write      <= 1'b0;
      cmd_valid  <= 1'b0;
      data_valid <= 1'b0;
      ad_out     <= `CEB_RST_WORD;
      ad_oe      <= 1'b0;
      busy       <= 1'b0;
      done       <= 1'b0;
      rdata      <= `CEB_RST_WORD;
    end else begin
      state      <= next_state;
      size       <= next_size;
      wdata      <= next_wdata;
      shift      <= next_shift;
      write      <= next_write;
      cmd_valid  <= next_cmd_valid;
      data_valid <= next_data_valid;
      ad_out     <= next_ad_out;
      ad_oe      <= next_ad_oe;
      busy       <= next_busy;
      done       <= next_done;
      rdata      <= next_rdata;
    end
  end

  assign link.cmd_valid  = cmd_valid;
  assign link.cmd_write  = write;
  assign link.cmd_size   = size;
  assign link.data_valid = data_valid;
  assign link.cpu_ad_out = ad_out;
  assign link.cpu_ad_oe  = ad_oe;
  assign BUSY            = busy;
  assign DONE            = done;
  assign RDATA           = rdata;

endmodule

// ==== rtl/ceb_dev_end.sv ====
// Purpose: Board end: decodes CPU transfers and steers byte lanes to targets
// Assumes: CPU keeps one transfer outstanding; targets answer with an ack
// Notes:   Top address nibble picks ROM, local 8-bit devices or memory/PCI
`include "ceb_defines.svh"
module ceb_dev_end (
  ceb_link_if.dev            link,
  input  wire logic          REF_CLK,
  input  wire logic          RST_N,
  input  wire logic          CFG_WR,
  input  wire logic          CFG_LITTLE,
  output logic               ENDIAN_LITTLE,
  output logic               PCI_SWAP_EN,
  output logic               MEM_REQ,
  output logic               MEM_WE,
  output logic [31:0]        MEM_ADDR,
  output logic [31:0]        MEM_WDATA,
  output logic [3:0]         MEM_BE,
  input  wire logic [31:0]   MEM_RDATA,
  input  wire logic          MEM_ACK,
  output logic               ROM_REQ,
  output logic [31:0]        ROM_ADDR,
  input  wire logic [7:0]    ROM_RDATA,
  input  wire logic          ROM_ACK,
  output logic               IO_REQ,
  output logic               IO_WE,
  output logic [31:0]        IO_ADDR,
  output logic [7:0]         IO_WDATA,
  input  wire logic [7:0]    IO_RDATA,
  input  wire logic          IO_ACK
);

  ceb_pkg::ceb_dev_state_t state,     next_state;
  ceb_pkg::ceb_size_t      size,      next_size;
  logic [31:0]             addr,      next_addr;
  logic [31:0]             wdata,     next_wdata;
  logic [31:0]             rdata,     next_rdata;
  logic                    write,     next_write;
  logic [1:0]              rom_cnt,   next_rom_cnt;
  logic                    little,    next_little;
  logic                    pci_swap,  next_pci_swap;
  logic                    ack,       next_ack;
  logic [31:0]             ad_out,    next_ad_out;
  logic                    ad_oe,     next_ad_oe;
  logic                    mem_req,   next_mem_req;
  logic                    mem_we,    next_mem_we;
  logic [31:0]             mem_addr,  next_mem_addr;
  logic [31:0]             mem_wdata, next_mem_wdata;
  logic [3:0]              mem_be,    next_mem_be;
  logic                    rom_req,   next_rom_req;
  logic [31:0]             rom_addr,  next_rom_addr;
  logic                    io_req,    next_io_req;
  logic                    io_we,     next_io_we;
  logic [31:0]             io_addr,   next_io_addr;
  logic [7:0]              io_wdata,  next_io_wdata;
  logic [3:0]              le_mask;
  logic [3:0]              be_mask;
  logic [3:0]              lane_mask;
  logic [3:0]              region;

  // ==========================================================
  // Byte ordering configuration
  always_comb begin
    next_little   = CFG_WR ? CFG_LITTLE : little;
    next_pci_swap = ~next_little;
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      little   <= `CEB_RST_LITTLE;
      pci_swap <= ~`CEB_RST_LITTLE;
    end else begin
      little   <= next_little;
      pci_swap <= next_pci_swap;
    end
  end

  // ==========================================================
  // Lane masks
  // Little-endian mask puts lane at the low address bits; the
  // big-endian mask is its mirror, so lane becomes three minus them
  always_comb begin
    unique case (size)
      ceb_pkg::CEB_BYTE: le_mask = `CEB_MASK_BYTE << addr[1:0];
      ceb_pkg::CEB_HALF: le_mask = addr[1] ? `CEB_MASK_HIHALF : `CEB_MASK_LOHALF;
      default:           le_mask = `CEB_MASK_WORD;
    endcase
  end

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_mirror
      assign be_mask[i] = le_mask[3 - i];
    end
  endgenerate

  always_comb begin
    lane_mask = little ? le_mask : be_mask;
  end

  assign region = addr[`CEB_REGION_MSB:`CEB_REGION_LSB];

  // ==========================================================
  // Transfer sequencing
  always_comb begin
    next_state     = state;
    next_size      = size;
    next_addr      = addr;
    next_wdata     = wdata;
    next_rdata     = rdata;
    next_write     = write;
    next_rom_cnt   = rom_cnt;
    next_ack       = 1'b0;
    next_ad_out    = `CEB_RST_WORD;
    next_ad_oe     = 1'b0;
    next_mem_req   = mem_req;
    next_mem_we    = mem_we;
    next_mem_addr  = mem_addr;
    next_mem_wdata = mem_wdata;
    next_mem_be    = mem_be;
    next_rom_req   = rom_req;
    next_rom_addr  = rom_addr;
    next_io_req    = io_req;
    next_io_we     = io_we;
    next_io_addr   = io_addr;
    next_io_wdata  = io_wdata;
    unique case (state)
      ceb_pkg::DEV_IDLE: begin
        if (link.cmd_valid) begin
          next_addr  = link.system_addr_data_bus;
          next_write = link.cmd_write;
          next_size  = link.cmd_size;
          next_state = link.cmd_write ? ceb_pkg::DEV_WDATA : ceb_pkg::DEV_DECODE;
        end
      end
      ceb_pkg::DEV_WDATA: begin
        if (link.data_valid) begin
          next_wdata = link.system_addr_data_bus;
          next_state = ceb_pkg::DEV_DECODE;
        end
      end
      ceb_pkg::DEV_DECODE: begin
        if (region == `CEB_REGION_ROM) begin
          if (write) begin
            // ROM is read only; a write is answered and dropped
            next_state = ceb_pkg::DEV_RESP;
          end else begin
            next_rom_req  = 1'b1;
            next_rom_addr = {addr[31:2], `CEB_WORD_ALIGN};
            next_rom_cnt  = 2'h0;
            next_rdata    = `CEB_RST_WORD;
            next_state    = ceb_pkg::DEV_ROM;
          end
        end else if (region == `CEB_REGION_IO) begin
          next_io_req   = 1'b1;
          next_io_we    = write;
          next_io_addr  = addr;
          next_io_wdata = wdata[7:0];
          next_state    = ceb_pkg::DEV_IO;
        end else begin
          next_mem_req   = 1'b1;
          next_mem_we    = write;
          next_mem_addr  = addr;
          next_mem_wdata = wdata;
          next_mem_be    = lane_mask;
          next_state     = ceb_pkg::DEV_MEM;
        end
      end
      ceb_pkg::DEV_ROM: begin
        if (ROM_ACK) begin
          // Byte k of the group always fills lane k, whatever the ordering
          next_rdata[{rom_cnt, 3'b000} +: 8] = ROM_RDATA;
          if (rom_cnt == `CEB_ROM_LAST) begin
            next_rom_req = 1'b0;
            next_state   = ceb_pkg::DEV_RESP;
          end else begin
            next_rom_cnt  = rom_cnt + 2'h1;
            next_rom_addr = rom_addr + `CEB_ROM_STEP;
          end
        end
      end
      ceb_pkg::DEV_IO: begin
        if (IO_ACK) begin
          next_io_req = 1'b0;
          next_rdata  = {24'h00_0000, IO_RDATA};
          next_state  = ceb_pkg::DEV_RESP;
        end
      end
      ceb_pkg::DEV_MEM: begin
        if (MEM_ACK) begin
          next_mem_req = 1'b0;
          next_rdata   = MEM_RDATA;
          next_state   = ceb_pkg::DEV_RESP;
        end
      end
      ceb_pkg::DEV_RESP: begin
        next_ack    = 1'b1;
        next_ad_oe  = ~write;
        next_ad_out = write ? `CEB_RST_WORD : rdata;
        next_state  = ceb_pkg::DEV_IDLE;
      end
      default: next_state = ceb_pkg::DEV_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state     <= ceb_pkg::DEV_IDLE;
      size      <= ceb_pkg::CEB_WORD;
      addr      <= `CEB_RST_WORD;
      wdata     <= `CEB_RST_WORD;
      rdata     <= `CEB_RST_WORD;
      write     <= 1'b0;
      rom_cnt   <= 2'h0;
      ack       <= 1'b0;
      ad_out    <= `CEB_RST_WORD;
      ad_oe     <= 1'b0;
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= `CEB_RST_WORD;
      mem_wdata <= `CEB_RST_WORD;
      mem_be    <= 4'h0;
      rom_req   <= 1'b0;
      rom_addr  <= `CEB_RST_WORD;
      io_req    <= 1'b0;
      io_we     <= 1'b0;
      io_addr   <= `CEB_RST_WORD;
      io_wdata  <= 8'h00;
    end else begin
      state     <= next_state;
      size      <= next_size;
      addr      <= next_addr;
      wdata     <= next_wdata;
      rdata     <= next_rdata;
      write     <= next_write;
      rom_cnt   <= next_rom_cnt;
      ack       <= next_ack;
      ad_out    <= next_ad_out;
      ad_oe     <= next_ad_oe;
      mem_req   <= next_mem_req;
      mem_we    <= next_mem_we;
      mem_addr  <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
      mem_be    <= next_mem_be;
      rom_req   <= next_rom_req;
      rom_addr  <= next_rom_addr;
      io_req    <= next_io_req;
      io_we     <= next_io_we;
      io_addr   <= next_io_addr;
      io_wdata  <= next_io_wdata;
    end
  end

  // ==========================================================
  // Outputs
  assign link.ack        = ack;
  assign link.dev_ad_out = ad_out;
  assign link.dev_ad_oe  = ad_oe;
  assign ENDIAN_LITTLE   = little;
  assign PCI_SWAP_EN     = pci_swap;
  assign MEM_REQ         = mem_req;
  assign MEM_WE          = mem_we;
  assign MEM_ADDR        = mem_addr;
  assign MEM_WDATA       = mem_wdata;
  assign MEM_BE          = mem_be;
  assign ROM_REQ         = rom_req;
  assign ROM_ADDR        = rom_addr;
  assign IO_REQ          = io_req;
  assign IO_WE           = io_we;
  assign IO_ADDR         = io_addr;
  assign IO_WDATA        = io_wdata;

endmodule

// ==== tb/ceb_link_assertions.sv ====
// Purpose: Concurrent checks on the link between the CPU end and the board end
// Assumes: One clock, asynchronous active low reset, one transfer outstanding
// Notes:   Instantiated beside the interface; sees only link signals
module ceb_link_assertions (
  input wire logic               REF_CLK,
  input wire logic               RST_N,
  input wire logic               cmd_valid,
  input wire logic               cmd_write,
  input wire ceb_pkg::ceb_size_t cmd_size,
  input wire logic               data_valid,
  input wire logic               ack,
  input wire logic [31:0]        cpu_ad_out,
  input wire logic               cpu_ad_oe,
  input wire logic [31:0]        dev_ad_out,
  input wire logic               dev_ad_oe,
  input wire logic [31:0]        system_addr_data_bus
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  // ==========================================================
  // Sequences
  sequence s_read_cmd;
    cmd_valid && !cmd_write;
  endsequence

  sequence s_write_cmd;
    cmd_valid && cmd_write;
  endsequence

  // ==========================================================
  // Properties
  property p_cmd_addr;
    cmd_valid |-> cpu_ad_oe && system_addr_data_bus == cpu_ad_out;
  endproperty
  a_cmd_addr: assert property (p_cmd_addr) else $error("address not on bus with command");

  property p_write_data;
    s_write_cmd |=> data_valid && cpu_ad_oe && !dev_ad_oe;
  endproperty
  a_write_data: assert property (p_write_data) else $error("write data phase missing");

  property p_read_gap;
    s_read_cmd |=> !ack [*3];
  endproperty
  a_read_gap: assert property (p_read_gap) else $error("read answered too early");

  property p_ack_bound;
    cmd_valid |-> ##[3:200] ack;
  endproperty
  a_ack_bound: assert property (p_ack_bound) else $error("transfer never acknowledged");

  property p_no_fight;
    !(cpu_ad_oe && dev_ad_oe);
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("both ends drive the bus");

  property p_dev_drive;
    dev_ad_oe |-> ack && !cmd_write && system_addr_data_bus == dev_ad_out;
  endproperty
  a_dev_drive: assert property (p_dev_drive) else $error("device drives outside read answer");

  property p_ack_pulse;
    ack |=> !ack && !dev_ad_oe;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

  property p_write_hold;
    s_write_cmd |=> $stable(cmd_write) && !cmd_valid;
  endproperty
  a_write_hold: assert property (p_write_hold) else $error("write flag or command changed");

  c_size_half: cover property (cmd_valid && cmd_size == ceb_pkg::CEB_HALF);
endmodule

// ==== tb/tb_cpu_endian_byte_lane_steering.sv ====
// Purpose: Self-checking bench joining both ends over the link interface
// Assumes: 25 MHz clock, targets answer with one-cycle acks
// Notes:   Lanes are judged only where the rules fix them
module tb_cpu_endian_byte_lane_steering;
  timeunit 1ns;
  timeprecision 1ps;

  logic        REF_CLK, RST_N, CPU_LITTLE, REQ, REQ_WRITE, BUSY, DONE, CFG_WR, CFG_LITTLE;
  logic        ENDIAN_LITTLE, PCI_SWAP_EN, MEM_REQ, MEM_WE, MEM_ACK, ROM_REQ, ROM_ACK;
  logic        IO_REQ, IO_WE, IO_ACK;
  logic [1:0]  REQ_SIZE;
  logic [3:0]  MEM_BE, mem_be;
  logic [7:0]  ROM_RDATA, IO_WDATA, IO_RDATA, io_wd, rom_count;
  logic [31:0] REQ_ADDR, REQ_WDATA, RDATA, MEM_ADDR, MEM_WDATA, MEM_RDATA, ROM_ADDR, IO_ADDR, mem_wd, exp;
  int          fail_count, total_checks;
  int          cycles = 0;

  ceb_link_if u_ceb_link_if ();
  ceb_cpu_end u_ceb_cpu_end (.link(u_ceb_link_if.cpu), .REF_CLK(REF_CLK), .RST_N(RST_N),
    .CPU_LITTLE(CPU_LITTLE), .REQ(REQ), .REQ_WRITE(REQ_WRITE), .REQ_SIZE(REQ_SIZE), .REQ_ADDR(REQ_ADDR),
    .REQ_WDATA(REQ_WDATA), .BUSY(BUSY), .DONE(DONE), .RDATA(RDATA));
  ceb_dev_end u_ceb_dev_end (.link(u_ceb_link_if.dev), .REF_CLK(REF_CLK), .RST_N(RST_N), .CFG_WR(CFG_WR),
    .CFG_LITTLE(CFG_LITTLE), .ENDIAN_LITTLE(ENDIAN_LITTLE), .PCI_SWAP_EN(PCI_SWAP_EN), .MEM_REQ(MEM_REQ),
    .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_BE(MEM_BE), .MEM_RDATA(MEM_RDATA),
    .MEM_ACK(MEM_ACK), .ROM_REQ(ROM_REQ), .ROM_ADDR(ROM_ADDR), .ROM_RDATA(ROM_RDATA), .ROM_ACK(ROM_ACK),
    .IO_REQ(IO_REQ), .IO_WE(IO_WE), .IO_ADDR(IO_ADDR), .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA),
    .IO_ACK(IO_ACK));
  ceb_link_assertions u_ceb_link_assertions (.REF_CLK(REF_CLK), .RST_N(RST_N),
    .cmd_valid(u_ceb_link_if.cmd_valid), .cmd_write(u_ceb_link_if.cmd_write),
    .cmd_size(u_ceb_link_if.cmd_size), .data_valid(u_ceb_link_if.data_valid), .ack(u_ceb_link_if.ack),
    .cpu_ad_out(u_ceb_link_if.cpu_ad_out), .cpu_ad_oe(u_ceb_link_if.cpu_ad_oe),
    .dev_ad_out(u_ceb_link_if.dev_ad_out), .dev_ad_oe(u_ceb_link_if.dev_ad_oe),
    .system_addr_data_bus(u_ceb_link_if.system_addr_data_bus));

  // ==========================================================
  // Clock, timeout and target responders
  initial begin
    REF_CLK = 1'b0;
    forever #20 REF_CLK = ~REF_CLK;
  end

  always @(posedge REF_CLK) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      end_sim();
    end
  end

  // Acks alternate so a held request is answered once per cycle pair
  always @(posedge REF_CLK) begin
    if (MEM_REQ === 1'b1) begin
      mem_be <= MEM_BE;
      mem_wd <= MEM_WDATA;
    end
    if (IO_REQ === 1'b1) io_wd <= IO_WDATA;
    // Byte count restarts with each CPU request
    if (REQ === 1'b1) rom_count <= 8'h00;
    else if (ROM_REQ === 1'b1 && ROM_ACK === 1'b1) rom_count <= rom_count + 8'h01;
    MEM_ACK   <= #1 MEM_REQ && !MEM_ACK;
    IO_ACK    <= #1 IO_REQ && !IO_ACK;
    ROM_ACK   <= #1 ROM_REQ && !ROM_ACK;
    ROM_RDATA <= #1 ROM_ADDR[7:0] ^ 8'h5A;
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] want, input string msg);
    total_checks++;
    if (got !== want) begin
      fail_count++;
      $display("MISMATCH t=%0t %s got %h want %h", $time, msg, got, want);
    end
  endtask

  task automatic xfer(input logic wr, input logic [1:0] sz, input logic [31:0] addr, input logic [31:0] wd);
    int i;
    @(posedge REF_CLK);
    #1;
    REQ = 1'b1;
    REQ_WRITE = wr;
    REQ_SIZE = sz;
    REQ_ADDR = addr;
    REQ_WDATA = wd;
    @(posedge REF_CLK);
    #1;
    REQ = 1'b0;
    chk({31'h0000_0000, BUSY}, 32'h0000_0001, "busy");
    for (i = 0; i < 60 && DONE !== 1'b1; i++) begin
      @(posedge REF_CLK);
      #1;
    end
    chk({31'h0000_0000, DONE}, 32'h0000_0001, "done");
    chk({31'h0000_0000, BUSY}, 32'h0000_0000, "busy drops with done");
  endtask

  task automatic set_endian(input logic little);
    @(posedge REF_CLK);
    #1;
    CFG_WR = 1'b1;
    CFG_LITTLE = little;
    CPU_LITTLE = little;
    @(posedge REF_CLK);
    #1;
    CFG_WR = 1'b0;
    chk({31'h0000_0000, ENDIAN_LITTLE}, {31'h0000_0000, little}, "ordering bit");
    chk({31'h0000_0000, PCI_SWAP_EN}, {31'h0000_0000, ~little}, "swapper");
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk({31'h0000_0000, ENDIAN_LITTLE}, 32'h0000_0000, "reset ordering");
    chk({31'h0000_0000, PCI_SWAP_EN}, 32'h0000_0001, "reset swapper");
  endtask

  task automatic t_bytes();
    int le, a, ln;
    for (le = 0; le < 2; le++) begin
      set_endian(le[0]);
      for (a = 0; a < 4; a++) begin
        ln = le ? a : 3 - a;
        xfer(1'b1, 2'h0, 32'h0000_0100 + a, 32'h0000_00A0 + a);
        chk({28'h000_0000, mem_be}, 32'h0000_0001 << ln, "byte lane enable");
        chk(mem_wd & (32'h0000_00FF << 8 * ln), (32'h0000_00A0 + a) << 8 * ln, "byte lane data");
        xfer(1'b0, 2'h0, 32'h0000_0100 + a, 32'h0000_0000);
        chk(RDATA, (MEM_RDATA >> 8 * ln) & 32'h0000_00FF, "byte read");
      end
    end
  endtask

  task automatic t_halves();
    int le, h;
    for (le = 0; le < 2; le++) begin
      set_endian(le[0]);
      for (h = 0; h < 2; h++) begin
        xfer(1'b1, 2'h1, 32'h0000_0200 + 2 * h, 32'h0000_1234);
        exp = (le == h) ? 32'h0000_000C : 32'h0000_0003;
        chk({28'h000_0000, mem_be}, exp, "half lane enable");
        chk(mem_wd, (exp == 32'h0000_000C) ? 32'h1234_0000 : 32'h0000_1234, "half lane data");
      end
    end
  endtask

  task automatic t_words_io();
    int le;
    for (le = 0; le < 2; le++) begin
      set_endian(le[0]);
      xfer(1'b1, 2'h2, 32'h0000_0300, 32'hDEAD_BEEF);
      chk(mem_wd, 32'hDEAD_BEEF, "word write");
      chk({28'h000_0000, mem_be}, 32'h0000_000F, "word enables");
      chk({31'h0000_0000, MEM_WE}, 32'h0000_0001, "memory write strobe");
      chk(MEM_ADDR, 32'h0000_0300, "memory address");
      xfer(1'b0, 2'h2, 32'h0000_0300, 32'h0000_0000);
      chk(RDATA, MEM_RDATA, "word read");
      chk({31'h0000_0000, MEM_WE}, 32'h0000_0000, "memory read strobe");
      xfer(1'b1, 2'h2, 32'hB000_0004, 32'h0000_003C);
      chk({24'h00_0000, io_wd}, 32'h0000_003C, "local write");
      chk({31'h0000_0000, IO_WE}, 32'h0000_0001, "local write strobe");
      chk(IO_ADDR, 32'hB000_0004, "local address");
      xfer(1'b0, 2'h2, 32'hB000_0004, 32'h0000_0000);
      chk(RDATA, {24'h00_0000, IO_RDATA}, "local read");
      chk({31'h0000_0000, IO_WE}, 32'h0000_0000, "local read strobe");
    end
  endtask

  task automatic t_rom();
    int le, k;
    for (le = 0; le < 2; le++) begin
      set_endian(le[0]);
      xfer(1'b0, 2'h2, 32'hF000_0010, 32'h0000_0000);
      for (k = 0; k < 4; k++) exp[8 * k +: 8] = (8'h10 + k[7:0]) ^ 8'h5A;
      chk({24'h00_0000, rom_count}, 32'h0000_0004, "rom byte reads");
      chk(RDATA, exp, "rom assembly");
      chk(ROM_ADDR, 32'hF000_0013, "rom last byte address");
      xfer(1'b1, 2'h2, 32'hF000_0010, 32'h0000_0000);
      chk(RDATA, exp, "rom write leaves read data");
    end
  endtask

  task automatic t_mid_reset();
    set_endian(1'b1);
    @(posedge REF_CLK);
    #1;
    RST_N = 1'b0;
    CPU_LITTLE = 1'b0;
    @(posedge REF_CLK);
    #1;
    RST_N = 1'b1;
    t_reset();
    xfer(1'b1, 2'h0, 32'h0000_0100, 32'h0000_00A0);
    chk({28'h000_0000, mem_be}, 32'h0000_0008, "byte lane after reset");
  endtask

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {RST_N, CPU_LITTLE, REQ, REQ_WRITE, CFG_WR, CFG_LITTLE} = 6'h00;
    {REQ_SIZE, REQ_ADDR, REQ_WDATA} = 66'h0;
    MEM_RDATA = 32'h1122_3344;
    IO_RDATA = 8'hC3;
    repeat (3) @(posedge REF_CLK);
    #1;
    RST_N = 1'b1;
    t_reset();
    t_bytes();
    t_halves();
    t_words_io();
    t_rom();
    t_mid_reset();
    end_sim();
  end
endmodule
